// *** rtl/iom_pkg.sv ***
// Shared constants and types of the io_multiplexer block
package iom_pkg;

  // ********************************
  // Memory word and address layout
  // ********************************
  localparam int WORD_W    = 36;  // Data bits per memory word
  localparam int ADDR_W    = 18;  // Word address width
  localparam int BLK_W     = 8;   // Width of the block count
  localparam int BLK_SHIFT = 10;  // Block of 1024 words
  localparam int TALLY_W   = 12;  // Double-word count of one area
  localparam int VEC_W     = 5;   // One of 32 vector locations
  localparam int ITYPE_W   = 2;   // One of four interrupt types
  localparam int CHK_W     = 20;  // Width used by the bounds check
  localparam logic [ADDR_W-1:0] ADDR_STEP = 18'h0_0002;  // Two words per access

  // ********************************
  // Mailbox pair fields
  // ********************************
  localparam int MB_BASE_LSB  = 0;   // Low word: protection base
  localparam int MB_BLK_LSB   = 18;  // Low word: block count
  localparam int MB_LIST_LSB  = 0;   // High word: list pointer
  localparam int MB_CNT_LSB   = 18;  // High word: control word count
  localparam int MB_VEC_LSB   = 26;  // High word: vector number

  // ********************************
  // Transfer control word pair fields
  // ********************************
  localparam int TC_ADDR_LSB  = 0;   // Low word: relative address
  localparam int TC_DIR_BIT   = 18;  // Low word: 1 = peripheral to memory
  localparam int TC_TALLY_LSB = 0;   // High word: double-word tally

  // ********************************
  // Interrupt types
  // ********************************
  localparam logic [ITYPE_W-1:0] INT_DONE   = 2'h0;  // List finished
  localparam logic [ITYPE_W-1:0] INT_BOUNDS = 2'h1;  // Area out of bounds
  localparam logic [ITYPE_W-1:0] INT_ATTN   = 2'h2;  // Peripheral status
  localparam logic [ITYPE_W-1:0] INT_PARITY = 2'h3;  // Memory parity fault

  // ********************************
  // Carrier types
  // ********************************
  typedef struct packed {
    logic              par;   // Odd parity over data
    logic [WORD_W-1:0] data;  // Word contents
  } iom_word_type;

  typedef struct packed {
    iom_word_type hi;  // Odd word of the pair
    iom_word_type lo;  // Even word of the pair
  } iom_pair_type;

endpackage

// *** rtl/iom_io_multiplexer.sv ***
// Protected list-driven io_multiplexer with its stream FIFO
//
// How it works
// [RL1] Only privileged software may assert start
// [RL2] Mailbox points to control word list
// [RL3] Moves data alone, sharing memory cycles
// [RL4] Steps list to gather or scatter areas
// [RL5] Mailbox carries requester's base and blocks
// [RL6] Every control word checked against limits
// [RL7] Out of bounds: skip transfer, interrupt
// [RL8] Four interrupt types, 32 vector locations
// [RL9] Completion and status reported by interrupt
// [RL10] Own direct path to all memory
// [RL11] Base plus block count; relocate by adding
// [RL12] 36-bit words with parity, pairs moved
// [RL13] First and last word checked before moving
`timescale 1ns/1ps

// ********************************
// Stream FIFO
// ********************************
module iom_fifo #(
  parameter int WIDTH = 74,  // Word width
  parameter int DEPTH = 16   // Number of entries
) (
  input  wire logic             mclk,       // System clock
  input  wire logic             reset_n,    // Async reset, low
  input  wire logic             in_valid,   // Fill side offers
  output logic                  in_ready,   // Room for a word
  input  wire logic [WIDTH-1:0] in_data,    // Fill data
  output logic                  out_valid,  // Word available
  input  wire logic             out_ready,  // Drain side takes
  output logic      [WIDTH-1:0] out_data    // Head word
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];  // Storage
  logic [AW-1:0]    wr_q;           // Write index
  logic [AW-1:0]    rd_q;           // Read index
  logic [AW:0]      cnt_q;          // Fill level
  logic             push;           // Accepted write
  logic             pop;            // Accepted read

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_q[rd_q];

  // Storage write
  always_ff @(posedge mclk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // Pointers and level
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ********************************
// Multiplexer top
// ********************************
module iom_io_multiplexer #(
  parameter int                    FIFO_DEPTH  = 16,     // Stream FIFO depth
  parameter logic [iom_pkg::VEC_W-1:0] ATTN_VECTOR = 5'h1F  // Status vector
) (
  input  wire logic                        mclk,            // 100 MHz clock
  input  wire logic                        reset_n,         // Async reset, low
  input  wire logic                        start,           // Start pulse
  input  wire logic [iom_pkg::ADDR_W-1:0]  start_mbx_addr,  // Mailbox address
  output logic                             busy,            // List in progress
  output logic                             mem_req,         // Memory request
  output logic                             mem_we,          // Write access
  output logic      [iom_pkg::ADDR_W-1:0]  mem_addr,        // Even word address
  output iom_pkg::iom_pair_type            mem_wdata,       // Write pair
  input  wire logic                        mem_ack,         // Access done
  input  wire iom_pkg::iom_pair_type       mem_rdata,       // Read pair
  output logic                             pout_valid,      // Data to peripheral
  input  wire logic                        pout_ready,      // Peripheral takes
  output iom_pkg::iom_pair_type            pout_data,       // Outgoing pair
  input  wire logic                        pin_valid,       // Peripheral offers
  output logic                             pin_ready,       // Room for pair
  input  wire iom_pkg::iom_pair_type       pin_data,        // Incoming pair
  input  wire logic                        periph_attn,     // Status pin
  output logic                             int_req,         // Interrupt level
  output logic      [iom_pkg::ITYPE_W-1:0] int_type,        // Interrupt type
  output logic      [iom_pkg::VEC_W-1:0]   int_vector,      // Vector number
  input  wire logic                        int_ack          // Interrupt taken
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_MBX, ST_DCW, ST_CHK, ST_MOVE, ST_IRQ
  } iom_state_type;

  iom_state_type                st_q;           // Sequencer state
  iom_state_type                st_d;           // Next state
  logic [iom_pkg::ADDR_W-1:0]   cur_addr_q;     // Memory address
  logic [iom_pkg::ADDR_W-1:0]   list_ptr_q;     // Next control word
  logic [iom_pkg::ADDR_W-1:0]   bar_base_q;     // Protection base
  logic [iom_pkg::BLK_W-1:0]    bar_blocks_q;   // Allowed blocks
  logic [iom_pkg::BLK_W-1:0]    dcw_left_q;     // Words still in list
  logic [iom_pkg::VEC_W-1:0]    vec_q;          // Requester's vector
  logic [iom_pkg::ADDR_W-1:0]   rel_addr_q;     // Area start, relative
  logic [iom_pkg::TALLY_W-1:0]  tally_q;        // Pairs left in area
  logic                         dir_q;          // 1 = into memory
  logic [iom_pkg::ITYPE_W-1:0]  itype_q;        // Pending type
  logic [iom_pkg::CHK_W-1:0]    last_rel;       // Last word, relative
  logic [iom_pkg::CHK_W-1:0]    limit;          // Allowed size in words
  logic                         in_bounds;      // Area allowed
  logic                         perr;           // Read parity fault
  logic                         ack_rd;         // Read data arrives
  logic                         out_ready;      // Outgoing FIFO room
  logic                         in_valid;       // Incoming FIFO data
  iom_pkg::iom_pair_type        in_head;        // Incoming FIFO head
  iom_pkg::iom_pair_type        pin_fixed;      // Reparitied input
  logic                         s1_q;           // Status sync stage 1
  logic                         s2_q;           // Status sync stage 2
  logic                         s3_q;           // Status sync stage 3
  logic                         lvl_q;          // Filtered status
  logic                         attn_rise;      // Status became active
  logic                         attn_pend_q;    // Status awaiting report
  logic                         int_req_q;      // Interrupt held
  logic                         fsm_load;       // Sequencer posts event
  logic                         attn_load;      // Status posts event

  // Odd parity for a word
  function automatic iom_pkg::iom_word_type mk_word(input logic [iom_pkg::WORD_W-1:0] d);
    mk_word.data = d;
    mk_word.par  = ~^d;
  endfunction

  // ********************************
  // Checks and memory handshake
  // ********************************
  // Bounds: first and last word of the area inside the block count
  assign limit = iom_pkg::CHK_W'({bar_blocks_q, {iom_pkg::BLK_SHIFT{1'b0}}});  // RL11
  assign last_rel = iom_pkg::CHK_W'(rel_addr_q) + iom_pkg::CHK_W'({tally_q, 1'b0})
                  - 20'h0_0001;  // RL13
  assign in_bounds = (tally_q != '0) && (last_rel < limit);  // RL6 RL13

  // Parity over both words of a read pair
  assign perr = ~(^mem_rdata.hi) | ~(^mem_rdata.lo);  // RL12

  // Requests go straight to memory, between processor cycles
  assign mem_req = (st_q == ST_MBX) || (st_q == ST_DCW)
                 || ((st_q == ST_MOVE) && (dir_q ? in_valid : out_ready));  // RL3 RL10
  assign mem_we    = (st_q == ST_MOVE) && dir_q;
  assign mem_addr  = cur_addr_q;
  assign mem_wdata = in_head;
  assign ack_rd    = mem_ack && !mem_we;
  assign busy      = (st_q != ST_IDLE);

  // Peripheral pairs regain parity before storage
  assign pin_fixed.hi = mk_word(pin_data.hi.data);
  assign pin_fixed.lo = mk_word(pin_data.lo.data);

  // ********************************
  // Stream buffers
  // ********************************
  iom_fifo #(
    .WIDTH ($bits(iom_pkg::iom_pair_type)),
    .DEPTH (FIFO_DEPTH)
  ) u_out_fifo (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .in_valid  ((st_q == ST_MOVE) && ack_rd && !perr),
    .in_ready  (out_ready),
    .in_data   (mem_rdata),
    .out_valid (pout_valid),
    .out_ready (pout_ready),
    .out_data  (pout_data)
  );

  iom_fifo #(
    .WIDTH ($bits(iom_pkg::iom_pair_type)),
    .DEPTH (FIFO_DEPTH)
  ) u_in_fifo (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .in_valid  (pin_valid),
    .in_ready  (pin_ready),
    .in_data   (pin_fixed),
    .out_valid (in_valid),
    .out_ready ((st_q == ST_MOVE) && mem_we && mem_ack),
    .out_data  (in_head)
  );

  // ********************************
  // Sequencer
  // ********************************
  // Next state
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE: begin
        if (start) begin  // RL1
          st_d = ST_MBX;
        end
      end
      ST_MBX: begin
        if (mem_ack) begin
          if (perr || (mem_rdata.hi.data[iom_pkg::MB_CNT_LSB +: iom_pkg::BLK_W] == '0)) begin
            st_d = ST_IRQ;
          end else begin
            st_d = ST_DCW;  // RL2
          end
        end
      end
      ST_DCW: begin
        if (mem_ack) begin
          st_d = perr ? ST_IRQ : ST_CHK;
        end
      end
      ST_CHK: begin
        st_d = in_bounds ? ST_MOVE : ST_IRQ;  // RL7
      end
      ST_MOVE: begin
        if (mem_ack) begin
          if (ack_rd && perr) begin
            st_d = ST_IRQ;
          end else if (tally_q == 12'h001) begin
            st_d = (dcw_left_q == '0) ? ST_IRQ : ST_DCW;  // RL4
          end
        end
      end
      ST_IRQ: begin
        if (!int_req_q) begin
          st_d = ST_IDLE;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // Mailbox and list bookkeeping
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      bar_base_q   <= '0;
      bar_blocks_q <= '0;
      list_ptr_q   <= '0;
      dcw_left_q   <= '0;
      vec_q        <= '0;
    end else if (mem_ack && !perr) begin
      if (st_q == ST_MBX) begin
        bar_base_q   <= mem_rdata.lo.data[iom_pkg::MB_BASE_LSB +: iom_pkg::ADDR_W];  // RL5
        bar_blocks_q <= mem_rdata.lo.data[iom_pkg::MB_BLK_LSB +: iom_pkg::BLK_W];    // RL5
        list_ptr_q   <= mem_rdata.hi.data[iom_pkg::MB_LIST_LSB +: iom_pkg::ADDR_W];  // RL2
        dcw_left_q   <= mem_rdata.hi.data[iom_pkg::MB_CNT_LSB +: iom_pkg::BLK_W];
        vec_q        <= mem_rdata.hi.data[iom_pkg::MB_VEC_LSB +: iom_pkg::VEC_W];   // RL8
      end else if (st_q == ST_DCW) begin
        list_ptr_q <= list_ptr_q + iom_pkg::ADDR_STEP;  // RL4
        dcw_left_q <= dcw_left_q - 8'h01;
      end
    end
  end

  // Current area and memory address
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cur_addr_q <= '0;
      rel_addr_q <= '0;
      tally_q    <= '0;
      dir_q      <= 1'b0;
    end else begin
      if (st_q == ST_IDLE && start) begin
        cur_addr_q <= start_mbx_addr;
      end else if (st_q == ST_MBX && mem_ack) begin
        cur_addr_q <= mem_rdata.hi.data[iom_pkg::MB_LIST_LSB +: iom_pkg::ADDR_W];
      end else if (st_q == ST_DCW && mem_ack) begin
        rel_addr_q <= mem_rdata.lo.data[iom_pkg::TC_ADDR_LSB +: iom_pkg::ADDR_W];
        dir_q      <= mem_rdata.lo.data[iom_pkg::TC_DIR_BIT];
        tally_q    <= mem_rdata.hi.data[iom_pkg::TC_TALLY_LSB +: iom_pkg::TALLY_W];
      end else if (st_q == ST_CHK) begin
        cur_addr_q <= bar_base_q + rel_addr_q;  // RL11
      end else if (st_q == ST_MOVE && mem_ack) begin
        tally_q <= tally_q - 12'h001;
        if (tally_q == 12'h001) begin
          cur_addr_q <= list_ptr_q;
        end else begin
          cur_addr_q <= cur_addr_q + iom_pkg::ADDR_STEP;  // RL12
        end
      end
    end
  end

  // Outcome of the running list
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      itype_q <= iom_pkg::INT_DONE;
    end else if (st_d == ST_IRQ && st_q != ST_IRQ) begin
      if (st_q == ST_CHK) begin
        itype_q <= iom_pkg::INT_BOUNDS;  // RL7
      end else if (ack_rd && perr) begin
        itype_q <= iom_pkg::INT_PARITY;
      end else begin
        itype_q <= iom_pkg::INT_DONE;  // RL9
      end
    end
  end

  // ********************************
  // Peripheral status input
  // ********************************
  // Three stages; a change counts once stages two and three agree
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s1_q  <= 1'b0;
      s2_q  <= 1'b0;
      s3_q  <= 1'b0;
      lvl_q <= 1'b0;
    end else begin
      s1_q <= periph_attn;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        lvl_q <= s3_q;
      end
    end
  end

  assign attn_rise = (s2_q == s3_q) && s3_q && !lvl_q;

  // ********************************
  // Interrupt output
  // ********************************
  assign fsm_load  = (st_q == ST_IRQ) && !int_req_q;
  assign attn_load = attn_pend_q && !int_req_q && !fsm_load;

  // Pending status event; a new edge wins over its clear
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      attn_pend_q <= 1'b0;
    end else begin
      attn_pend_q <= attn_rise | (attn_pend_q & ~attn_load);  // RL9
    end
  end

  // Held request with type and vector until taken
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      int_req_q  <= 1'b0;
      int_type   <= iom_pkg::INT_DONE;
      int_vector <= '0;
    end else if (fsm_load) begin
      int_req_q  <= 1'b1;
      int_type   <= itype_q;  // RL8
      int_vector <= vec_q;    // RL8
    end else if (attn_load) begin
      int_req_q  <= 1'b1;
      int_type   <= iom_pkg::INT_ATTN;  // RL9
      int_vector <= ATTN_VECTOR;
    end else if (int_ack) begin
      int_req_q <= 1'b0;
    end
  end

  assign int_req = int_req_q;
endmodule

// *** tb/iom_mem_model.sv ***
// Memory system model answering the multiplexer's pair accesses
`timescale 1ns/1ps
module iom_mem_model (
  input  wire logic                  mclk,       // System clock
  input  wire logic                  reset_n,    // Async reset, low
  input  wire logic                  mem_req,    // Request level
  input  wire logic                  mem_we,     // Write access
  input  wire logic [17:0]           mem_addr,   // Even word address
  input  wire iom_pkg::iom_pair_type mem_wdata,  // Write pair
  output logic                       mem_ack,    // Access done pulse
  output iom_pkg::iom_pair_type      mem_rdata,  // Read pair
  input  wire logic [3:0]            lat,        // Wait cycles before ack
  input  wire logic                  bad_par     // Corrupt read parity
);
  iom_pkg::iom_pair_type mem [0:4095];  // Pair store holding lists and data
  logic [3:0]            wait_q;        // Cycles waited so far

  // ********************************
  // Access sequencing
  // ********************************
  // Address bits 12:1 pick one of 4096 pairs; slow or prompt answers share the memory cycles
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mem_ack   <= 1'b0;
      wait_q    <= 4'h0;
      mem_rdata <= '0;
    end else begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;  // Released bus toggles, showing the last value only every other cycle
      if (mem_req && !mem_ack) begin
        if (wait_q >= lat) begin
          mem_ack   <= 1'b1;
          wait_q    <= 4'h0;
          mem_rdata <= mem[mem_addr[12:1]] ^ (74'(bad_par) << 36);
          if (mem_we) begin
            mem[mem_addr[12:1]] <= mem_wdata;
          end
        end else begin
          wait_q <= wait_q + 4'h1;
        end
      end
    end
  end
endmodule

// *** tb/iom_properties.sv ***
// Port-level checks of the multiplexer
`timescale 1ns/1ps
module iom_props #(
  parameter logic [4:0] ATTN_VECTOR = 5'h1F  // Status vector
) (
  input wire logic                  mclk,            // System clock
  input wire logic                  reset_n,         // Async reset, low
  input wire logic                  start,           // Start pulse
  input wire logic [17:0]           start_mbx_addr,  // Mailbox address
  input wire logic                  busy,            // List in progress
  input wire logic                  mem_req,         // Memory request
  input wire logic                  mem_we,          // Write access
  input wire logic [17:0]           mem_addr,        // Even word address
  input wire iom_pkg::iom_pair_type mem_wdata,       // Write pair
  input wire logic                  mem_ack,         // Access done
  input wire logic                  pout_valid,      // Outbound valid
  input wire logic                  pout_ready,      // Outbound ready
  input wire iom_pkg::iom_pair_type pout_data,       // Outbound pair
  input wire logic                  periph_attn,     // Status pin
  input wire logic                  int_req,         // Interrupt level
  input wire logic [1:0]            int_type,        // Interrupt type
  input wire logic [4:0]            int_vector,      // Vector number
  input wire logic                  int_ack          // Interrupt taken
);
  // ********************************
  // Assertions
  // ********************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  chk_fetch_mbx: assert property (start && !busy |=> busy && mem_req && mem_addr == $past(start_mbx_addr))
    else $error("no mailbox fetch");
  chk_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("request changed early");
  chk_wdata_hold: assert property (mem_req && mem_we && !mem_ack |=> $stable(mem_wdata))
    else $error("write pair changed early");
  chk_pair_even: assert property (mem_req |-> !mem_addr[0])
    else $error("odd pair address");
  chk_wr_parity: assert property (mem_req && mem_we |-> (^mem_wdata.lo) && (^mem_wdata.hi))
    else $error("written pair lacks odd parity");
  chk_idle_quiet: assert property (!busy |-> !mem_req)
    else $error("memory used while idle");
  chk_pout_hold: assert property (pout_valid && !pout_ready |=> pout_valid && $stable(pout_data))
    else $error("outbound pair dropped");
  chk_int_hold: assert property (int_req && !int_ack |=> int_req && $stable(int_type) && $stable(int_vector))
    else $error("interrupt changed early");
  chk_int_clear: assert property (int_req && int_ack |=> !int_req)
    else $error("interrupt not cleared by ack");
  chk_list_idle: assert property ($rose(int_req) && int_type != iom_pkg::INT_ATTN |-> !busy)
    else $error("busy with list interrupt");
  chk_attn_vec: assert property (int_req && int_type == iom_pkg::INT_ATTN |-> int_vector == ATTN_VECTOR)
    else $error("status interrupt on wrong vector");
  chk_attn_raise: assert property ($rose(periph_attn) && !int_req && !busy
                                   |-> ##[1:8] int_req && int_type == iom_pkg::INT_ATTN)
    else $error("status edge not reported");
  cover property ($rose(int_req) && int_type == iom_pkg::INT_DONE);
  cover property ($rose(int_req) && int_type == iom_pkg::INT_BOUNDS);
  cover property ($rose(int_req) && int_type == iom_pkg::INT_PARITY);
endmodule

bind iom_io_multiplexer iom_props #(.ATTN_VECTOR(ATTN_VECTOR)) iom_props_inst (.*);

// *** tb/testbench.sv ***
// Self-checking bench of the multiplexer with its memory model
`timescale 1ns/1ps
module testbench;
  logic                  mclk, reset_n, start, busy;         // Clock and control
  logic                  mem_req, mem_we, mem_ack;           // Memory handshake
  logic                  pout_valid, pout_ready;             // Outbound stream
  logic                  pin_valid, pin_ready;               // Inbound stream
  logic                  periph_attn, int_req, int_ack;      // Status and interrupt
  logic                  bad_par, hold;                      // Fault and stall knobs
  logic [17:0]           start_mbx_addr, mem_addr;           // Addresses
  logic [3:0]            lat;                                // Memory wait
  logic [1:0]            int_type;                           // Interrupt type
  logic [4:0]            int_vector;                         // Vector number
  iom_pkg::iom_pair_type mem_wdata, mem_rdata, pout_data, pin_data;  // Pairs
  iom_pkg::iom_pair_type outq [$];                           // Pairs seen outbound
  int                    fails, cmp_count, cyc, pi, pn, npi, rd_cnt;  // Bookkeeping

  iom_io_multiplexer iom_io_multiplexer_inst (.*);
  iom_mem_model      iom_mem_model_inst (.*);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ********************************
  // Helpers
  // ********************************
  function automatic logic [35:0] dv(input int a);  // Word pattern of an address
    return {a[17:0], ~a[17:0]};
  endfunction
  function automatic iom_pkg::iom_word_type pr(input logic [35:0] d);  // Odd parity word
    return {~^d, d};
  endfunction
  function automatic iom_pkg::iom_pair_type mp(input int a);  // Pair at even address
    return {pr(dv(a + 1)), pr(dv(a))};
  endfunction
  task automatic put(input int a, input int lo, input int hi);  // Preload one pair
    iom_mem_model_inst.mem[a / 2] = {pr(36'(hi)), pr(36'(lo))};
  endtask
  task automatic chk(input string nm, input logic [73:0] exp, input logic [73:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic go(input int mbx);  // Supervisor start of a list
    @(posedge mclk);
    start          <= 1'b1;
    start_mbx_addr <= 18'(mbx);
    @(posedge mclk);
    start          <= 1'b0;
  endtask
  task automatic wint(input logic [1:0] ty, input int vc);  // Wait, judge, acknowledge
    int n;
    for (n = 0; n < 3000 && int_req !== 1'b1; n++) begin
      @(posedge mclk);
      #1;
    end
    chk("int_type", ty, int_type);
    if (vc >= 0) chk("int_vector", vc, int_vector);
    if (ty != iom_pkg::INT_ATTN) chk("busy", 0, busy);
    @(posedge mclk);
    int_ack <= 1'b1;
    @(posedge mclk);
    int_ack <= 1'b0;
  endtask
  task automatic wout(input int n);  // Wait for outbound pairs
    for (int k = 0; k < 600 && outq.size() < n; k++) @(posedge mclk);
    chk("out_count", n, outq.size());
  endtask
  task conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Far-side streams, read counter and timeout
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc > 30000) begin
      fails++;
      conclude();
    end
    if (pout_valid && pout_ready) outq.push_back(pout_data);
    if (mem_req && mem_ack && !mem_we && mem_addr >= 18'h0_0400) rd_cnt++;
    pout_ready <= !hold && (cyc % 3 != 0);  // Peripheral stalls now and then
    npi = pi + int'(pin_valid && pin_ready);
    pi        <= npi;
    pin_valid <= npi < pn;
    pin_data  <= {1'b0, dv(npi * 2 + 'h7001), 1'b0, dv(npi * 2 + 'h7000)};  // Parity left wrong
  end

  // ********************************
  // Scenarios
  // ********************************
  task automatic t_reset;
    #1;
    chk("reset_outs", 0, {busy, mem_req, pout_valid, int_req, int_type, int_vector});
    reset_n <= 1'b1;
    @(posedge mclk);
    #1;
    chk("pin_ready", 1, pin_ready);
    $display("test reset done");
  endtask
  task automatic t_gather;  // Two areas, stalled peripheral fills the buffer
    lat  <= 4'h2;
    hold <= 1'b1;
    put('h100, 'h400 | 2 << 18, 'h110 | 2 << 18 | 10 << 26);
    put('h110, 'h10, 18);
    put('h112, 'h600, 2);
    go('h100);
    repeat (300) @(posedge mclk);
    chk("fifo_fill", 16, rd_cnt);
    hold <= 1'b0;
    wint(iom_pkg::INT_DONE, 10);
    wout(20);
    for (int k = 0; k < 20; k++) chk("gather", mp(k < 18 ? 'h410 + 2 * k : 'hA00 + 2 * (k - 18)), outq[k]);
    $display("test gather done");
  endtask
  task automatic t_scatter;  // Peripheral to memory with parity regenerated
    int k0;
    k0 = pn;
    lat <= 4'h0;
    put('h120, 'h800 | 1 << 18, 'h130 | 1 << 18 | 3 << 26);
    put('h130, 'h20 | 1 << 18, 3);
    pn <= pn + 3;
    go('h120);
    wint(iom_pkg::INT_DONE, 3);
    for (int k = 0; k < 3; k++) chk("scatter", mp('h7000 + 2 * (k0 + k)), iom_mem_model_inst.mem['h410 + k]);
    chk("past_area", mp('h826), iom_mem_model_inst.mem['h413]);
    $display("test scatter done");
  endtask
  task automatic t_bounds;  // Last word in range, next area two words over
    int n0;
    lat <= 4'h1;
    outq.delete();
    n0 = rd_cnt;
    put('h140, 'h1000 | 1 << 18, 'h150 | 2 << 18 | 7 << 26);
    put('h150, 'h3FC, 2);
    put('h152, 'h3FE, 2);
    go('h140);
    wint(iom_pkg::INT_BOUNDS, 7);
    repeat (40) @(posedge mclk);
    chk("bound_reads", n0 + 2, rd_cnt);
    chk("bound_out", 2, outq.size());
    chk("bound_first", mp('h13FC), outq[0]);
    $display("test bounds done");
  endtask
  task automatic t_empty;  // Empty list and zero tally
    put('h160, 0, 'h170 | 17 << 26);
    go('h160);
    wint(iom_pkg::INT_DONE, 17);
    put('h168, 4 << 18, 'h170 | 1 << 18 | 9 << 26);
    put('h170, 0, 0);
    go('h168);
    wint(iom_pkg::INT_BOUNDS, 9);
    bad_par <= 1'b1;
    go('h160);
    wint(iom_pkg::INT_PARITY, -1);
    bad_par <= 1'b0;
    $display("test empty and parity done");
  endtask
  task automatic t_attn;  // Peripheral status edge
    periph_attn <= 1'b1;
    repeat (5) @(posedge mclk);
    periph_attn <= 1'b0;
    wint(iom_pkg::INT_ATTN, 'h1F);
    $display("test status done");
  endtask

  initial begin
    {start, int_ack, periph_attn, bad_par, hold, pin_valid, pout_ready, reset_n} = 8'h00;
    {start_mbx_addr, lat, pin_data} = '0;
    {fails, cmp_count, cyc, pi, pn, rd_cnt} = '0;
    for (int i = 0; i < 4096; i++) iom_mem_model_inst.mem[i] = mp(2 * i);
    repeat (6) @(posedge mclk);
    t_reset();
    t_gather();
    t_scatter();
    t_bounds();
    t_empty();
    t_attn();
    conclude();
  end
endmodule
